// ==== verilog/cns_node_engine.sv ====
/*
 * Node service engine: expedited SDO server, NMT slave state machine, boot-up,
 * heartbeat producer and consumer, SYNC-held commands and emergency frames.
 * Assumes a CAN data-link controller on both frame ports and a stable node_id.
 */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - SDO requests arrive on 0x600+node; replies leave on 0x580+node.
// - Byte 0 command, bytes 1-2 index low first, byte 3 subindex, bytes 4-7 data.
// - Requests 0x23/0x2B/0x2F write 4/2/1 bytes, 0x40 reads, 0x80 aborts.
// - Replies 0x43/0x4B/0x4F for reads, 0x60 for writes, 0x80 for abort.
// - Longer payloads need segments ending with a flag; segments here are refused.
// - Either side may abort; an abort discards the transfer without reply.
// - Power-up enters initialization, then moves on by itself to pre-operational.
// - NMT 0x01 operational, 0x02 stopped, 0x80 pre-op, 0x81/0x82 resets.
// - NMT frame id 0, byte 0 specifier, byte 1 node, 0 means all.
// - NMT commands are obeyed silently, never answered.
// - Application reset flows into communication reset; resets accepted from any run state.
// - Services gated by state: SDO/SYNC/EMCY in pre-op or operational only.
// - Heartbeat is the only error control; guarding requests are ignored.
// - With producer time nonzero, heartbeat frames repeat at that period.
// - Consumer flags a fault when its producer stays silent past the timeout.
// - One boot-up frame is sent on entering pre-operational after initialization.
// - In synchronous mode state commands other than the two resets wait for the next SYNC.
// - Error onset sends emergency with its code; clearing sends code 0.
// - Emergency on 0x80+node: code bytes 0-1, error register, vendor bytes 3-7.
// - Error register reads 0 none, 1 generic, 0x80 internal; also object 0x1001.
// - Dictionary entries are selected by 16-bit index plus 8-bit subindex.
// - Identifier is 4-bit function code above the 7-bit node number.
module cns_node_engine #(
    parameter int TICK_CYCLES = cns_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Configuration
    input wire logic [6:0] node_id,
    input wire logic sync_mode,
    // Frames from the link
    input wire logic rx_valid,
    output logic rx_ready,
    input wire cns_pkg::cns_frame_s rx_frame,
    // Frames to the link
    output logic tx_valid,
    input wire logic tx_ready,
    output cns_pkg::cns_frame_s tx_frame,
    // Application error report
    input wire logic err_active,
    input wire logic err_internal,
    input wire logic [15:0] err_code,
    input wire logic [39:0] err_vendor,
    // Status
    output cns_pkg::cns_nmt_e nmt_state,
    output logic pdo_enable,
    output logic sync_pulse,
    output logic hb_fault,
    output logic [7:0] err_reg
);
    typedef struct packed {
        cns_pkg::cns_nmt_e nmt;
        logic [15:0] ms_cnt;
        logic held_vld;
        logic [7:0] held_cs;
        logic sync_seen;
        logic sdo_pend;
        cns_pkg::cns_frame_s sdo_frm;
        logic boot_pend;
        logic hb_pend;
        logic [15:0] hb_time;
        logic [15:0] hb_cnt;
        logic [31:0] hbc_cfg;
        logic [15:0] hbc_cnt;
        logic hbc_fault;
        logic emcy_pend;
        cns_pkg::cns_frame_s emcy_frm;
        logic err_seen;
        logic [7:0] err_reg;
        cns_pkg::cns_frame_s [1:0] buf_frm;
        logic wptr;
        logic rptr;
        logic [1:0] cnt;
    } cns_state_s;

    cns_state_s st_q;
    cns_state_s st_d;

    logic rx_fire;
    logic tick;
    logic node_ok;
    logic run_st;
    logic svc_st;
    logic [7:0] cmd;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [31:0] val;
    logic is_nmt;
    logic is_sync;
    logic is_sdo;
    logic is_hb;
    logic tx_fire;

    function automatic cns_pkg::cns_nmt_e nmt_apply(cns_pkg::cns_nmt_e cur, logic [7:0] cs);
        case (cs)
            cns_pkg::CS_START: nmt_apply = cns_pkg::CNS_OPER;
            cns_pkg::CS_STOP: nmt_apply = cns_pkg::CNS_STOP;
            cns_pkg::CS_PREOP: nmt_apply = cns_pkg::CNS_PREOP;
            cns_pkg::CS_RST_APP: nmt_apply = cns_pkg::CNS_RST_APP;
            cns_pkg::CS_RST_COM: nmt_apply = cns_pkg::CNS_RST_COM;
            default: nmt_apply = cur;
        endcase
    endfunction

    function automatic logic [7:0] hb_byte(cns_pkg::cns_nmt_e s);
        case (s)
            cns_pkg::CNS_OPER: hb_byte = cns_pkg::HB_OPER;
            cns_pkg::CNS_STOP: hb_byte = cns_pkg::HB_STOP;
            default: hb_byte = cns_pkg::HB_PREOP;
        endcase
    endfunction

    assign rx_fire = rx_valid && rx_ready;
    assign tx_fire = tx_valid && tx_ready;
    assign tick = (st_q.ms_cnt == 16'(TICK_CYCLES - 1));
    assign node_ok = (node_id != 7'h00);
    assign run_st = (st_q.nmt == cns_pkg::CNS_PREOP) || (st_q.nmt == cns_pkg::CNS_OPER)
        || (st_q.nmt == cns_pkg::CNS_STOP);
    assign svc_st = (st_q.nmt == cns_pkg::CNS_PREOP) || (st_q.nmt == cns_pkg::CNS_OPER);
    assign cmd = rx_frame.data[7:0];
    assign idx = rx_frame.data[23:8];
    assign sub = rx_frame.data[31:24];
    assign val = rx_frame.data[63:32];
    assign is_nmt = (rx_frame.id == cns_pkg::NMT_ID) && (rx_frame.dlc >= 4'h2)
        && ((rx_frame.data[15:8] == 8'h00) || (rx_frame.data[15:8] == {1'b0, node_id}));
    assign is_sync = (rx_frame.id == cns_pkg::SYNC_ID);
    assign is_sdo = node_ok && (rx_frame.id == {cns_pkg::FC_SDO_RX, node_id});
    assign is_hb = (st_q.hbc_cfg[22:16] != 7'h00) && (rx_frame.id == {cns_pkg::FC_HB, st_q.hbc_cfg[22:16]});

    always_comb begin
        st_d = st_q;
        st_d.sync_seen = 1'b0;
        st_d.ms_cnt = tick ? 16'h0000 : 16'(st_q.ms_cnt + 16'h0001);

        // Drain side of the two-entry buffer
        if (tx_fire) begin
            st_d.rptr = ~st_q.rptr;
        end
        // Fill side; one frame per cycle, SDO reply first
        if (st_q.cnt != 2'h2 || tx_fire) begin
            if (st_q.sdo_pend) begin
                st_d.buf_frm[st_q.wptr] = st_q.sdo_frm;
                st_d.sdo_pend = 1'b0;
                st_d.wptr = ~st_q.wptr;
            end else if (st_q.emcy_pend) begin
                st_d.buf_frm[st_q.wptr] = st_q.emcy_frm;
                st_d.emcy_pend = 1'b0;
                st_d.wptr = ~st_q.wptr;
            end else if (st_q.boot_pend) begin
                st_d.buf_frm[st_q.wptr] = '{id: {cns_pkg::FC_HB, node_id}, dlc: 4'h1,
                    data: {56'h0, cns_pkg::HB_BOOT}};
                st_d.boot_pend = 1'b0;
                st_d.wptr = ~st_q.wptr;
            end else if (st_q.hb_pend) begin
                st_d.buf_frm[st_q.wptr] = '{id: {cns_pkg::FC_HB, node_id}, dlc: 4'h1,
                    data: {56'h0, hb_byte(st_q.nmt)}};
                st_d.hb_pend = 1'b0;
                st_d.wptr = ~st_q.wptr;
            end
        end
        st_d.cnt = 2'(st_q.cnt + {1'b0, st_d.wptr != st_q.wptr} - {1'b0, tx_fire});

        // Node state sequencing
        case (st_q.nmt)
            cns_pkg::CNS_INIT: begin
                st_d.nmt = cns_pkg::CNS_RST_APP;
            end
            cns_pkg::CNS_RST_APP: begin
                st_d.err_seen = 1'b0;
                st_d.err_reg = cns_pkg::ERR_NONE;
                st_d.emcy_pend = 1'b0;
                st_d.nmt = cns_pkg::CNS_RST_COM;
            end
            cns_pkg::CNS_RST_COM: begin
                st_d.hb_time = cns_pkg::HB_TIME_RST;
                st_d.hbc_cfg = cns_pkg::HB_CONS_RST;
                st_d.hb_cnt = 16'h0000;
                st_d.hbc_cnt = 16'h0000;
                st_d.hbc_fault = 1'b0;
                st_d.hb_pend = 1'b0;
                st_d.held_vld = 1'b0;
                st_d.boot_pend = 1'b1;
                st_d.nmt = cns_pkg::CNS_PREOP;
            end
            cns_pkg::CNS_PREOP, cns_pkg::CNS_OPER, cns_pkg::CNS_STOP: begin
            end
            default: begin
                st_d.nmt = cns_pkg::CNS_INIT;
            end
        endcase

        // Heartbeat producer, only while running
        if (!run_st || st_q.hb_time == 16'h0000) begin
            st_d.hb_cnt = 16'h0000;
        end else if (tick) begin
            if (16'(st_q.hb_cnt + 16'h0001) >= st_q.hb_time) begin
                st_d.hb_cnt = 16'h0000;
                st_d.hb_pend = 1'b1;
            end else begin
                st_d.hb_cnt = 16'(st_q.hb_cnt + 16'h0001);
            end
        end

        // Heartbeat consumer
        if (st_q.hbc_cfg[15:0] == 16'h0000) begin
            st_d.hbc_cnt = 16'h0000;
            st_d.hbc_fault = 1'b0;
        end else if (tick && !st_q.hbc_fault) begin
            if (16'(st_q.hbc_cnt + 16'h0001) >= st_q.hbc_cfg[15:0]) begin
                st_d.hbc_fault = 1'b1;
            end else begin
                st_d.hbc_cnt = 16'(st_q.hbc_cnt + 16'h0001);
            end
        end

        // Emergency on each change of the error condition; waits while not allowed
        if (svc_st && !st_q.emcy_pend && (err_active != st_q.err_seen)) begin
            st_d.err_seen = err_active;
            st_d.err_reg = !err_active ? cns_pkg::ERR_NONE
                : (err_internal ? cns_pkg::ERR_INTERNAL : cns_pkg::ERR_GENERIC);
            st_d.emcy_pend = 1'b1;
            st_d.emcy_frm = '{id: 11'(cns_pkg::EMCY_BASE + {4'h0, node_id}), dlc: 4'h8,
                data: {err_vendor, st_d.err_reg, (err_active ? err_code : 16'h0000)}};
        end

        if (rx_fire) begin
            // Silent obedience, no frame is queued here
            if (is_nmt && run_st) begin
                if ((rx_frame.data[7:0] == cns_pkg::CS_RST_APP) || (rx_frame.data[7:0] == cns_pkg::CS_RST_COM)) begin
                    st_d.nmt = nmt_apply(st_q.nmt, rx_frame.data[7:0]);
                    st_d.held_vld = 1'b0;
                end else if (sync_mode) begin
                    st_d.held_vld = 1'b1;
                    st_d.held_cs = rx_frame.data[7:0];
                end else begin
                    st_d.nmt = nmt_apply(st_q.nmt, rx_frame.data[7:0]);
                end
            end
            if (is_sync && svc_st) begin
                st_d.sync_seen = 1'b1;
                if (st_q.held_vld) begin
                    st_d.nmt = nmt_apply(st_q.nmt, st_q.held_cs);
                    st_d.held_vld = 1'b0;
                end
            end
            // Alive heartbeat clears the fault in the same cycle a timeout would set it
            if (is_hb) begin
                st_d.hbc_cnt = 16'h0000;
                st_d.hbc_fault = 1'b0;
            end
            if (is_sdo && svc_st) begin
                st_d.sdo_frm.id = {cns_pkg::FC_SDO_TX, node_id};
                st_d.sdo_frm.dlc = 4'h8;
                st_d.sdo_frm.data = {32'h0, sub, idx, cns_pkg::SDO_WR_OK};
                st_d.sdo_pend = 1'b1;
                case (cmd)
                    cns_pkg::SDO_WR4, cns_pkg::SDO_WR2, cns_pkg::SDO_WR1: begin
                        if (idx == cns_pkg::IDX_HB_PROD && sub == 8'h00) begin
                            st_d.hb_time = (cmd == cns_pkg::SDO_WR1) ? {8'h00, val[7:0]} : val[15:0];
                            st_d.hb_cnt = 16'h0000;
                        end else if (idx == cns_pkg::IDX_HB_CONS && sub == 8'h01) begin
                            st_d.hbc_cfg = (cmd == cns_pkg::SDO_WR4) ? val
                                : ((cmd == cns_pkg::SDO_WR2) ? {16'h0, val[15:0]} : {24'h0, val[7:0]});
                            st_d.hbc_cnt = 16'h0000;
                            st_d.hbc_fault = 1'b0;
                        end else if (idx == cns_pkg::IDX_DEV_TYPE || idx == cns_pkg::IDX_ERR_REG
                            || idx == cns_pkg::IDX_HB_CONS) begin
                            st_d.sdo_frm.data = {cns_pkg::ABORT_RD_ONLY, sub, idx, cns_pkg::SDO_ABORT};
                        end else begin
                            st_d.sdo_frm.data = {cns_pkg::ABORT_NO_OBJ, sub, idx, cns_pkg::SDO_ABORT};
                        end
                    end
                    cns_pkg::SDO_RD: begin
                        if (idx == cns_pkg::IDX_DEV_TYPE && sub == 8'h00) begin
                            st_d.sdo_frm.data = {cns_pkg::DEV_TYPE_VAL, sub, idx, cns_pkg::SDO_RD4_OK};
                        end else if (idx == cns_pkg::IDX_ERR_REG && sub == 8'h00) begin
                            st_d.sdo_frm.data = {24'h0, st_q.err_reg, sub, idx, cns_pkg::SDO_RD1_OK};
                        end else if (idx == cns_pkg::IDX_HB_CONS && sub == 8'h00) begin
                            st_d.sdo_frm.data = {32'h1, sub, idx, cns_pkg::SDO_RD1_OK};
                        end else if (idx == cns_pkg::IDX_HB_CONS && sub == 8'h01) begin
                            st_d.sdo_frm.data = {st_q.hbc_cfg, sub, idx, cns_pkg::SDO_RD4_OK};
                        end else if (idx == cns_pkg::IDX_HB_PROD && sub == 8'h00) begin
                            st_d.sdo_frm.data = {16'h0, st_q.hb_time, sub, idx, cns_pkg::SDO_RD2_OK};
                        end else begin
                            st_d.sdo_frm.data = {cns_pkg::ABORT_NO_OBJ, sub, idx, cns_pkg::SDO_ABORT};
                        end
                    end
                    cns_pkg::SDO_ABORT: begin
                        st_d.sdo_pend = 1'b0;
                    end
                    default: begin
                        // Segmented transfers are not served; the client sees an abort
                        st_d.sdo_frm.data = {cns_pkg::ABORT_BAD_CMD, sub, idx, cns_pkg::SDO_ABORT};
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
            st_q.nmt <= cns_pkg::CNS_INIT;
        end else begin
            st_q <= st_d;
        end
    end

    // A pending SDO reply stalls all further incoming frames, not only SDO requests
    assign rx_ready = !st_q.sdo_pend;
    assign tx_valid = (st_q.cnt != 2'h0);
    assign tx_frame = st_q.buf_frm[st_q.rptr];
    assign nmt_state = st_q.nmt;
    assign pdo_enable = (st_q.nmt == cns_pkg::CNS_OPER);
    assign sync_pulse = st_q.sync_seen;
    assign hb_fault = st_q.hbc_fault;
    assign err_reg = st_q.err_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_sdo_reply_id: assert property (rx_fire && is_sdo && svc_st && cmd != cns_pkg::SDO_ABORT
        |=> st_q.sdo_pend && st_q.sdo_frm.id == {cns_pkg::FC_SDO_TX, node_id})
        else $error("SDO reply not queued on server identifier");
    chk_read_code: assert property (rx_fire && is_sdo && svc_st && cmd == cns_pkg::SDO_RD
        && idx == cns_pkg::IDX_HB_PROD && sub == 8'h00
        |=> st_q.sdo_frm.data[7:0] == cns_pkg::SDO_RD2_OK)
        else $error("Two-byte read answered with wrong code");
    chk_write_store: assert property (rx_fire && is_sdo && svc_st && cmd == cns_pkg::SDO_WR2
        && idx == cns_pkg::IDX_HB_PROD && sub == 8'h00
        |=> st_q.hb_time == $past(val[15:0]) && st_q.sdo_frm.data[7:0] == cns_pkg::SDO_WR_OK)
        else $error("Write did not store or confirm");
    chk_boot_seq: assert property ($rose(st_q.nmt == cns_pkg::CNS_RST_APP)
        |=> st_q.nmt == cns_pkg::CNS_RST_COM ##1 st_q.nmt == cns_pkg::CNS_PREOP && st_q.boot_pend)
        else $error("Reset sequence did not reach pre-operational with boot-up");
    chk_sdo_gated: assert property (rx_fire && is_sdo && st_q.nmt == cns_pkg::CNS_STOP
        && !st_q.sdo_pend |=> !st_q.sdo_pend)
        else $error("SDO served while stopped");
    chk_nmt_silent: assert property (rx_fire && is_nmt && !is_sdo && !st_q.sdo_pend
        |=> !st_q.sdo_pend)
        else $error("NMT command produced a reply");
    chk_sync_hold: assert property (rx_fire && is_nmt && run_st && sync_mode
        && rx_frame.data[7:0] == cns_pkg::CS_START && !(st_q.nmt == cns_pkg::CNS_OPER)
        |=> st_q.nmt != cns_pkg::CNS_OPER && st_q.held_vld)
        else $error("Held command applied before SYNC");
    chk_hb_timeout: assert property (tick && st_q.hbc_cfg[15:0] != 16'h0000 && !st_q.hbc_fault
        && 16'(st_q.hbc_cnt + 16'h0001) >= st_q.hbc_cfg[15:0] && !(rx_fire && (is_hb || is_sdo))
        |=> st_q.hbc_fault)
        else $error("Consumer timeout not flagged");
    chk_emcy_clear: assert property ($fell(st_q.err_seen) && svc_st
        |-> st_q.emcy_pend && st_q.emcy_frm.data[15:0] == 16'h0000 && err_reg == cns_pkg::ERR_NONE)
        else $error("Error clear did not queue zero-code emergency");
    chk_tx_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
        else $error("Stalled frame changed or vanished");

    cov_sdo_read: cover property (rx_fire && is_sdo && cmd == cns_pkg::SDO_RD ##[1:4] tx_fire);
    cov_heartbeat: cover property (st_q.hb_pend ##[1:4] tx_fire);
    cov_sync_apply: cover property (st_q.held_vld ##[1:50] st_q.sync_seen);
    cov_buf_full: cover property (st_q.cnt == 2'h2 && !tx_ready);
endmodule
`default_nettype wire

// ==== common/cns_pkg.sv ====
/*
 * Shared constants, frame layout and node states for the node service engine.
 * Assumes an 11-bit identifier CAN controller that passes whole frames in and out.
 */
`default_nettype none
package cns_pkg;
    // Frame as exchanged with the data-link controller; data[7:0] is byte 0
    typedef struct packed {
        logic [10:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } cns_frame_s;

    typedef enum logic [5:0] {
        CNS_INIT    = 6'h01,
        CNS_RST_APP = 6'h02,
        CNS_RST_COM = 6'h04,
        CNS_PREOP   = 6'h08,
        CNS_OPER    = 6'h10,
        CNS_STOP    = 6'h20
    } cns_nmt_e;

    // Identifiers
    localparam logic [10:0] NMT_ID = 11'h000;
    localparam logic [10:0] SYNC_ID = 11'h080;
    localparam logic [10:0] EMCY_BASE = 11'h080;
    localparam logic [3:0] FC_SDO_TX = 4'hb;
    localparam logic [3:0] FC_SDO_RX = 4'hc;
    localparam logic [3:0] FC_HB = 4'he;

    // Client commands and server replies
    localparam logic [7:0] SDO_WR4 = 8'h23;
    localparam logic [7:0] SDO_WR2 = 8'h2b;
    localparam logic [7:0] SDO_WR1 = 8'h2f;
    localparam logic [7:0] SDO_RD = 8'h40;
    localparam logic [7:0] SDO_ABORT = 8'h80;
    localparam logic [7:0] SDO_RD4_OK = 8'h43;
    localparam logic [7:0] SDO_RD2_OK = 8'h4b;
    localparam logic [7:0] SDO_RD1_OK = 8'h4f;
    localparam logic [7:0] SDO_WR_OK = 8'h60;
    localparam logic [31:0] ABORT_NO_OBJ = 32'h06020000;
    localparam logic [31:0] ABORT_RD_ONLY = 32'h06010002;
    localparam logic [31:0] ABORT_BAD_CMD = 32'h05040001;

    // Network management command specifiers
    localparam logic [7:0] CS_START = 8'h01;
    localparam logic [7:0] CS_STOP = 8'h02;
    localparam logic [7:0] CS_PREOP = 8'h80;
    localparam logic [7:0] CS_RST_APP = 8'h81;
    localparam logic [7:0] CS_RST_COM = 8'h82;

    // Heartbeat state bytes and boot-up payload
    localparam logic [7:0] HB_BOOT = 8'h00;
    localparam logic [7:0] HB_PREOP = 8'h7f;
    localparam logic [7:0] HB_OPER = 8'h05;
    localparam logic [7:0] HB_STOP = 8'h04;

    // Dictionary entries served
    localparam logic [15:0] IDX_DEV_TYPE = 16'h1000;
    localparam logic [15:0] IDX_ERR_REG = 16'h1001;
    localparam logic [15:0] IDX_HB_CONS = 16'h1016;
    localparam logic [15:0] IDX_HB_PROD = 16'h1017;
    localparam logic [31:0] DEV_TYPE_VAL = 32'h00000000; // Arbitrary value
    localparam logic [15:0] HB_TIME_RST = 16'h0000;
    localparam logic [31:0] HB_CONS_RST = 32'h00000000;

    // Error register values
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_GENERIC = 8'h01;
    localparam logic [7:0] ERR_INTERNAL = 8'h80;

    // Millisecond time base
    localparam int CLK_HZ = 10000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
endpackage
`default_nettype wire

// ==== dv/cns_master_model.sv ====
/* Network master model: offers frames to the engine and takes its frames,
   stalling at random. Assumes inputs change 1 ns after the rising edge. */
`timescale 1ns/10ps
`default_nettype none
module cns_master_model (
    // Clock, reset, setup
    input wire logic mclk,
    input wire logic rst,
    input wire logic stall,
    input wire logic [6:0] node_id,
    // Frames to the engine
    output logic rx_valid,
    input wire logic rx_ready,
    output cns_pkg::cns_frame_s rx_frame,
    // Frames from the engine
    input wire logic tx_valid,
    output logic tx_ready,
    input wire cns_pkg::cns_frame_s tx_frame
);
    cns_pkg::cns_frame_s got[$];
    int hb_n = 0;
    logic [7:0] hb_last = '0;
    initial begin
        rx_valid = 0;
        rx_frame = '0;
        tx_ready = 0;
    end
    // Heartbeats are counted apart so they never disturb reply order
    always @(posedge mclk) begin
        if (!rst && tx_valid && tx_ready) begin
            if (tx_frame.id == {4'he, node_id} && tx_frame.dlc == 4'h1 && tx_frame.data[7:0] != 8'h00) begin
                hb_n++;
                hb_last = tx_frame.data[7:0];
            end else begin
                got.push_back(tx_frame);
            end
        end
        #1 tx_ready = !stall && $urandom_range(1, 0);
    end
    // Released data is inverted so stale bytes never pass as valid
    task automatic send(input cns_pkg::cns_frame_s f);
        rx_valid = 1;
        rx_frame = f;
        do @(negedge mclk); while (!rx_ready);
        @(posedge mclk);
        #1 rx_valid = 0;
        rx_frame = ~f;
        // Idle edge, so a following call never re-raises valid in the same step
        @(posedge mclk);
        #1;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
/* Self-checking bench for the node engine with a master model on the link.
   Assumes the millisecond tick shortened to 10 cycles. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int TK = 10;
    logic mclk = 0, rst = 1, stall = 0, sync_mode = 0, err_active = 0, err_internal = 0, sync_seen = 0;
    logic [6:0] node_id = 7'h2a;
    logic [15:0] err_code = '0;
    logic [39:0] err_vendor = '0;
    logic rx_valid, rx_ready, tx_valid, tx_ready, pdo_enable, sync_pulse, hb_fault;
    cns_pkg::cns_frame_s rx_frame, tx_frame;
    cns_pkg::cns_nmt_e nmt_state;
    logic [7:0] err_reg;
    int failures = 0, compares = 0, n, hb;
    always #50 mclk = ~mclk;
    always @(posedge mclk) if (sync_pulse === 1'b1) sync_seen <= 1;
    cns_node_engine #(.TICK_CYCLES(TK)) dut (
        .mclk(mclk), .rst(rst), .node_id(node_id), .sync_mode(sync_mode),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_frame(rx_frame),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame),
        .err_active(err_active), .err_internal(err_internal), .err_code(err_code), .err_vendor(err_vendor),
        .nmt_state(nmt_state), .pdo_enable(pdo_enable), .sync_pulse(sync_pulse), .hb_fault(hb_fault),
        .err_reg(err_reg)
    );
    cns_master_model mm (
        .mclk(mclk), .rst(rst), .stall(stall), .node_id(node_id),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_frame(rx_frame),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame)
    );
    task automatic cmp(input logic [63:0] g, e, input string what);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %0t: %s got %h exp %h", $time, what, g, e);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask
    task automatic st(input cns_pkg::cns_nmt_e e);
        cyc(3);
        cmp({58'h0, nmt_state}, {58'h0, e}, "state");
    endtask
    task automatic frm(input logic [10:0] id, input logic [63:0] d, m);
        int w = 0;
        while (mm.got.size() == 0 && w < 300) begin
            cyc(1);
            w++;
        end
        if (mm.got.size() == 0) cmp(64'h1, 64'h0, "no frame");
        else begin
            cmp({53'h0, mm.got[0].id}, {53'h0, id}, "id");
            cmp(mm.got.pop_front().data & m, d & m, "data");
        end
    endtask
    task automatic sdo(input logic [7:0] c, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] v);
        mm.send({11'h600 + {4'h0, node_id}, 4'h8, v, sb, ix, c});
    endtask
    task automatic xfer(input logic [7:0] c, r, input logic [15:0] ix, input logic [7:0] sb,
                        input logic [31:0] v, rv, rm);
        sdo(c, ix, sb, v);
        frm(11'h580 + {4'h0, node_id}, {rv, sb, ix, r}, {rm, 32'hffffffff});
    endtask
    task automatic nmt(input logic [7:0] cs, nd);
        mm.send({11'h0, 4'h2, 48'h0, nd, cs});
    endtask
    task automatic conclude;
        $display("Compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(100 * 40000);
        failures++;
        conclude;
    end
    initial begin
        void'($urandom(32'h459ff03c));
        node_id = 7'($urandom_range(127, 1));
        repeat (20) @(posedge mclk);
        #1 rst = 0;
        frm({4'he, node_id}, 64'h0, 64'hff);
        st(cns_pkg::CNS_PREOP);
        xfer(8'h40, 8'h4b, 16'h1017, 0, 0, 0, 32'hffff);
        xfer(8'h40, 8'h43, 16'h1000, 0, 0, cns_pkg::DEV_TYPE_VAL, '1);
        xfer(8'h40, 8'h4f, 16'h1001, 0, 0, 0, 32'hff);
        xfer(8'h2f, 8'h80, 16'h1001, 0, 1, cns_pkg::ABORT_RD_ONLY, '1);
        xfer(8'h40, 8'h80, 16'h2000, 0, 0, cns_pkg::ABORT_NO_OBJ, '1);
        xfer(8'h99, 8'h80, 16'h1017, 0, 0, cns_pkg::ABORT_BAD_CMD, '1);
        hb = $urandom_range(4, 2);
        xfer(8'h2b, 8'h60, 16'h1017, 0, hb, 0, 0);
        xfer(8'h40, 8'h4b, 16'h1017, 0, 0, hb, 32'hffff);
        n = mm.hb_n;
        cyc(hb * TK * 4 + 5);
        cmp({63'h0, mm.hb_n - n inside {[3:5]}}, 64'h1, "hb count");
        cmp({56'h0, mm.hb_last}, 64'h7f, "hb byte");
        xfer(8'h2b, 8'h60, 16'h1017, 0, 0, 0, 0);
        sdo(8'h80, 16'h1017, 0, 0);
        mm.send({11'h601 + {4'h0, node_id}, 4'h8, 64'h40});
        nmt(cns_pkg::CS_START, 0);
        st(cns_pkg::CNS_OPER);
        cmp({63'h0, pdo_enable}, 64'h1, "pdo");
        nmt(cns_pkg::CS_STOP, {1'b0, node_id});
        st(cns_pkg::CNS_STOP);
        cmp({63'h0, pdo_enable}, 64'h0, "pdo off");
        sdo(8'h40, 16'h1001, 0, 0);
        cyc(20);
        cmp(64'(mm.got.size()), 64'h0, "silent");
        nmt(cns_pkg::CS_PREOP, {1'b0, node_id} + 8'h1);
        st(cns_pkg::CNS_STOP);
        nmt(cns_pkg::CS_PREOP, {1'b0, node_id});
        st(cns_pkg::CNS_PREOP);
        nmt(cns_pkg::CS_RST_APP, 0);
        frm({4'he, node_id}, 64'h0, 64'hff);
        nmt(cns_pkg::CS_RST_COM, {1'b0, node_id});
        frm({4'he, node_id}, 64'h0, 64'hff);
        sync_mode = 1;
        nmt(cns_pkg::CS_START, 0);
        st(cns_pkg::CNS_PREOP);
        cmp({63'h0, sync_seen}, 64'h0, "no sync");
        mm.send({cns_pkg::SYNC_ID, 4'h0, 64'h0});
        st(cns_pkg::CNS_OPER);
        cmp({63'h0, sync_seen}, 64'h1, "sync");
        sync_mode = 0;
        err_code = 16'($urandom_range(16'hffff, 1));
        err_vendor = 40'({$urandom, $urandom});
        for (int i = 1; i >= 0; i--) begin
            err_internal = i[0];
            err_active = 1;
            frm(cns_pkg::EMCY_BASE + node_id, {err_vendor, i[0] ? 8'h80 : 8'h01, err_code}, '1);
            cmp({56'h0, err_reg}, i[0] ? 64'h80 : 64'h01, "err reg");
            err_active = 0;
            frm(cns_pkg::EMCY_BASE + node_id, 64'h0, 64'hffffff);
            cmp({56'h0, err_reg}, 64'h0, "err clear");
        end
        xfer(8'h23, 8'h60, 16'h1016, 1, 32'h00050002, 0, 0);
        xfer(8'h40, 8'h43, 16'h1016, 1, 0, 32'h00050002, '1);
        cyc(4 * TK + 5);
        cmp({63'h0, hb_fault}, 64'h1, "hb timeout");
        mm.send({11'h705, 4'h1, 64'h05});
        cyc(3);
        cmp({63'h0, hb_fault}, 64'h0, "hb seen");
        stall = 1;
        fork
            begin
                cyc(40);
                stall = 0;
            end
        join_none
        repeat (3) sdo(8'h40, 16'h1001, 0, 0);
        repeat (3) frm(11'h580 + {4'h0, node_id}, 64'h0010014f, 64'hffffffffff);
        conclude;
    end
endmodule
`default_nettype wire
